//--- inc/pmt_defs.vh
`ifndef PMT_DEFS_VH
`define PMT_DEFS_VH
`define PMT_ADDR_W 13
`define PMT_WORD_W 16
`define PMT_DEPTH 8192
`define PMT_RESET_VECTOR 13'h0000
`define PMT_PHASES 4
`define PMT_PHASE_LAST 2'h3
`define PMT_HIGH_BITS 5
`define PMT_SECTOR_W 2
`define PMT_SECTOR_ZERO 2'h0
`define PMT_INSN_CYCLES 2
`endif

//--- core/pmt_rom.v
`timescale 1ns/1ns
`include "pmt_defs.vh"

module pmt_rom (
	input wire ref_clk,
	input wire [12:0] fetchAddr,
	input wire [12:0] tableAddr,
	input wire loadEn,
	input wire [12:0] loadAddr,
	input wire [15:0] loadData,
	output reg [15:0] fetchWord,
	output reg [15:0] tableWord
);
	// Flip-flop storage; two read ports so fetch and table read never collide.
	reg [15:0] mem [0:`PMT_DEPTH-1];

	// Contents come from the loader port; storage has no reset, like a flash array.
	always @(posedge ref_clk) begin
		if (loadEn) begin
			mem[loadAddr] <= loadData;
		end
		fetchWord <= mem[fetchAddr];
		tableWord <= mem[tableAddr];
	end
endmodule

//--- core/pmt_table_read.v
`timescale 1ns/1ns
`include "pmt_defs.vh"
// Operation
// - 8K by 16-bit program memory
// - Fetch starts at location zero after reset
// - Table data addressed by table pointer
// - Address formed from both pointer registers
// - Low byte goes to chosen data register
// - High byte goes to table high-byte register
// - Missing high-byte bits read as zero
// - Plain reads sector zero, extended others
// - Table instructions take two instruction cycles
// - High-byte register software readable and writable
// - Four phases per instruction cycle

module pmt_table_read (
	input wire ref_clk,
	input wire srst,
	input wire pcAdvance,
	input wire pcLoad,
	input wire [12:0] pcLoadValue,
	input wire [7:0] tablePtrLow,
	input wire [7:0] tablePtrHigh,
	input wire readStart,
	input wire readExtended,
	input wire lastPageSel,
	input wire [7:0] destAddr,
	input wire [1:0] destSector,
	input wire highByteWrite,
	input wire [7:0] highByteWriteData,
	input wire loadEn,
	input wire [12:0] loadAddr,
	input wire [15:0] loadData,
	output reg [1:0] phase,
	output wire cycleStart,
	output reg [12:0] programCounter,
	output reg [15:0] instrWord,
	output wire tableBusy,
	output reg destWrite,
	output reg [7:0] destWriteAddr,
	output reg [1:0] destWriteSector,
	output reg [7:0] destWriteData,
	output reg sectorError,
	output reg [7:0] table_high_byte
);
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_DONE = 2'h2;

	reg [1:0] state;
	reg [1:0] next_state;
	reg [12:0] tableAddr;
	reg [7:0] pendAddr;
	reg [1:0] pendSector;
	wire [15:0] fetchWord;
	wire [15:0] tableWord;
	wire phaseEnd;
	wire takeNow;
	wire deliverNow;
	wire [7:0] highPtr;
	reg [12:0] next_tableAddr;
	reg [7:0] next_pendAddr;
	reg [1:0] next_pendSector;
	reg next_sectorError;
	reg next_destWrite;
	reg [7:0] next_destWriteAddr;
	reg [1:0] next_destWriteSector;
	reg [7:0] next_destWriteData;
	reg [7:0] next_highByte;

	// Join the two pointer registers into one word address.
	function [12:0] join_ptr;
		input [7:0] lo;
		input [7:0] hi;
		begin
			join_ptr = {hi[`PMT_HIGH_BITS-1:0], lo};
		end
	endfunction

	assign phaseEnd = (phase == `PMT_PHASE_LAST);
	assign cycleStart = (phase == 2'h0);
	assign tableBusy = (state != ST_IDLE);

	// A read is taken on the last phase only while idle, so a request that
	// arrives in mid-sequence simply waits for the next free boundary.
	assign takeNow = (state == ST_IDLE) && readStart && phaseEnd;
	assign deliverNow = (state == ST_DONE) && phaseEnd;
	// The last-page variant swaps the high pointer for the top page.
	assign highPtr = lastPageSel ? 8'hff : tablePtrHigh;

	// Program store; fetch and table read have separate ports, but the counter does not advance while a table read is busy.
	pmt_rom u_rom (
		.ref_clk(ref_clk),
		.fetchAddr(programCounter),
		.tableAddr(tableAddr),
		.loadEn(loadEn),
		.loadAddr(loadAddr),
		.loadData(loadData),
		.fetchWord(fetchWord),
		.tableWord(tableWord)
	);

	// Four phase counter; one lap is one instruction cycle.
	always @(posedge ref_clk) begin
		if (srst) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	// Program counter moves only at a cycle boundary so it changes as phase zero begins.
	always @(posedge ref_clk) begin
		if (srst) begin
			programCounter <= `PMT_RESET_VECTOR;
			instrWord <= 16'h0000;
		end else if (phaseEnd) begin
			instrWord <= fetchWord;
			if (pcLoad) begin
				programCounter <= pcLoadValue;
			end else if (pcAdvance && !tableBusy) begin
				programCounter <= programCounter + 13'h0001;
			end
		end
	end

	// Table read sequencer: one cycle to fetch the word, one to deliver it.
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (readStart && phaseEnd) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (phaseEnd) begin
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				if (phaseEnd) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Capture address and destination when the instruction is taken.
	always @* begin
		next_tableAddr = tableAddr;
		next_pendAddr = pendAddr;
		next_pendSector = pendSector;
		next_sectorError = sectorError;
		if (takeNow) begin
			next_tableAddr = join_ptr(tablePtrLow, highPtr);
			next_pendAddr = destAddr;
			next_pendSector = destSector;
			// A plain read may only reach sector zero; the extended variant reaches any.
			next_sectorError = !readExtended && (destSector != `PMT_SECTOR_ZERO);
		end
	end

	// Pending read registers; they hold until the next read is taken.
	always @(posedge ref_clk) begin
		if (srst) begin
			tableAddr <= 13'h0000;
			pendAddr <= 8'h00;
			pendSector <= 2'h0;
			sectorError <= 1'b0;
		end else begin
			tableAddr <= next_tableAddr;
			pendAddr <= next_pendAddr;
			pendSector <= next_pendSector;
			sectorError <= next_sectorError;
		end
	end

	// Delivery values; the strobe falls again one clock after it rises.
	always @* begin
		next_destWrite = 1'b0;
		next_destWriteAddr = destWriteAddr;
		next_destWriteSector = destWriteSector;
		next_destWriteData = destWriteData;
		next_highByte = table_high_byte;
		if (deliverNow) begin
			next_destWrite = !sectorError;
			next_destWriteAddr = pendAddr;
			next_destWriteSector = pendSector;
			next_destWriteData = tableWord[7:0];
			// All 16 word bits exist, so no bit of the high byte is forced to zero.
			next_highByte = tableWord[15:8];
		end else if (highByteWrite) begin
			// A software write loses to a delivery in the same clock, since the read is newer.
			next_highByte = highByteWriteData;
		end
	end

	// Delivery registers; a refused plain read still loads the high byte but no data register.
	always @(posedge ref_clk) begin
		if (srst) begin
			destWrite <= 1'b0;
			destWriteAddr <= 8'h00;
			destWriteSector <= 2'h0;
			destWriteData <= 8'h00;
			table_high_byte <= 8'h00;
		end else begin
			destWrite <= next_destWrite;
			destWriteAddr <= next_destWriteAddr;
			destWriteSector <= next_destWriteSector;
			destWriteData <= next_destWriteData;
			table_high_byte <= next_highByte;
		end
	end
endmodule

//--- testbench/pmt_props.sv
`timescale 1ns/1ns
// Checks phase order, table read timing, counter steps and the high-byte register.
module pmt_props(input wire ref_clk, srst, pcAdvance, pcLoad, readStart, readExtended,
	highByteWrite, tableBusy, destWrite, input wire [1:0] phase, destSector,
	input wire [12:0] programCounter, input wire [7:0] highByteWriteData, table_high_byte);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// A read is taken only at the last phase while idle.
	wire take = phase == 2'h3 && readStart && !tableBusy;
	property p_ph; !$past(srst) |-> phase == $past(phase) + 2'h1; endproperty
	a_ph: assert property (p_ph) else $error("phase step");
	property p_lat; take && (readExtended || destSector == 2'h0) |-> ##9 destWrite; endproperty
	a_lat: assert property (p_lat) else $error("late write");
	property p_ref; take && !readExtended && destSector != 2'h0 |-> ##9 !destWrite; endproperty
	a_ref: assert property (p_ref) else $error("sector write");
	property p_busy; take |=> tableBusy [*8] ##1 !tableBusy; endproperty
	a_busy: assert property (p_busy) else $error("busy drop");
	property p_rst; disable iff (1'b0) srst |=> programCounter == 13'h0 && phase == 2'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset entry");
	property p_pc; phase != 2'h3 |=> $stable(programCounter); endproperty
	a_pc: assert property (p_pc) else $error("pc moved");
	property p_adv; phase == 2'h3 && pcAdvance && !pcLoad && !tableBusy && !readStart
		|=> programCounter == $past(programCounter) + 13'h1; endproperty
	a_adv: assert property (p_adv) else $error("pc step");
	property p_hb; highByteWrite && !tableBusy |=> table_high_byte == $past(highByteWriteData);
	endproperty
	a_hb: assert property (p_hb) else $error("high byte write");
endmodule
bind pmt_table_read pmt_props u_props(.*);

//--- testbench/pmt_core_model.sv
`timescale 1ns/1ns
// Core side: holds its request up until the block shows busy; a request made while an earlier read is still busy is dropped.
module pmt_core_model(input wire ref_clk, go, tableBusy, output reg readStart);
	initial readStart = 1'b0;
	always @(negedge ref_clk) begin
		if (go)
			readStart <= 1'b1;
		else if (tableBusy)
			readStart <= 1'b0;
	end
endmodule

//--- testbench/test_program_memory_table_read.sv
`timescale 1ns/1ns
module test_program_memory_table_read;
	reg ref_clk = 0, srst = 1, pcAdvance = 0, pcLoad = 0, readExtended = 0, lastPageSel = 0;
	reg highByteWrite = 0, loadEn = 0, go = 0;
	reg [12:0] pcLoadValue = 0, loadAddr = 0;
	reg [15:0] loadData = 0;
	reg [7:0] tablePtrLow = 0, tablePtrHigh = 0, destAddr = 0, highByteWriteData = 0;
	reg [1:0] destSector = 0;
	wire readStart, cycleStart, tableBusy, destWrite, sectorError;
	wire [1:0] phase, destWriteSector;
	wire [12:0] programCounter;
	wire [15:0] instrWord;
	wire [7:0] destWriteAddr, destWriteData, table_high_byte;
	integer n_mismatch = 0, comparisons = 0, i, a, t;
	int mem[int];
	pmt_table_read DUT(.*);
	pmt_core_model core(.*);
	initial forever #10 ref_clk = ~ref_clk;
	task chk(input logic [15:0] s, e, input string n);
		comparisons++;
		if (e !== s) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task close_out;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// A hang gives up at 1000 cycles, well past the fewer than 200 cycles that the reads need.
	initial begin
		#20000;
		n_mismatch++;
		close_out;
	end
	initial begin
		void'($urandom(59784));
		repeat (3) @(negedge ref_clk);
		srst = 0;
		chk(programCounter, 0, "pc");
		chk(cycleStart, 1, "cycle");
		for (i = 0; i < 8; i++) begin
			@(negedge ref_clk);
			tablePtrLow = $urandom;
			tablePtrHigh = $urandom;
			lastPageSel = i[2];
			a = lastPageSel ? {5'h1f, tablePtrLow} : {tablePtrHigh[4:0], tablePtrLow};
			mem[a] = $urandom & 32'hffff;
			loadEn = 1;
			loadAddr = a;
			loadData = mem[a];
			@(negedge ref_clk);
			loadEn = 0;
			readExtended = i[0];
			destSector = $urandom;
			destAddr = $urandom;
			go <= 1;
			@(negedge ref_clk);
			go <= 0;
			t = 0;
			while (destWrite !== 1'b1 && t < 16) begin
				@(posedge ref_clk);
				#1 t++;
			end
			if (readExtended || destSector == 0) begin
				chk(destWrite, 1, "strobe");
				chk(destWriteData, mem[a] & 255, "data");
				chk(destWriteAddr, destAddr, "addr");
				chk(destWriteSector, destSector, "wsector");
				chk(sectorError, 0, "sector");
			end else begin
				chk(sectorError, 1, "sector");
				chk(destWrite, 0, "strobe");
			end
			chk(table_high_byte, mem[a] >> 8, "high");
		end
		@(negedge ref_clk);
		highByteWrite = 1;
		highByteWriteData = 8'h5a;
		@(negedge ref_clk);
		highByteWrite = 0;
		chk(table_high_byte, 8'h5a, "hbw");
		// Known words at the reset entry and the next location, so the fetch path is checked.
		for (i = 0; i < 2; i++) begin
			mem[i] = 16'h1234 + i;
			loadEn = 1;
			loadAddr = i;
			loadData = mem[i];
			@(negedge ref_clk);
		end
		loadEn = 0;
		pcAdvance = 1;
		a = programCounter;
		repeat (8) @(negedge ref_clk);
		chk(programCounter, a + 2, "adv");
		chk(instrWord, mem[a + 1], "fetch");
		close_out;
	end
endmodule
